//--- hw/gpm_power_ctrl.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: 15-bit bipolar current samples accumulated internally
// RULE_02: Positive sense difference means charge, negative discharge
// RULE_03: Voltage sampled each second, scaled to millivolts
// RULE_04: Thermistor select picks external or internal sensor
// RULE_05: Normal mode refreshes all data every second
// RULE_06: Doze halts processor, measures every 20 seconds
// RULE_07: Enter doze when enabled and current small
// RULE_08: Deep doze measures every 20 s, oscillator off
// RULE_09: Lines held low up to 4 ms on exit
// RULE_10: Nonzero wait setting auto-enters deep doze
// RULE_11: Zero wait: request command enters deep doze
// RULE_12: Request ignored while nonzero wait is counting
// RULE_13: Communication wake resets wait counter, others keep
// RULE_14: Leave deep doze on command, current, or wake
// RULE_15: Dormant needs relaxed reading and small current
// RULE_16: Dormant on request flag or low voltage
// RULE_17: Stay dormant until command or current rises
// RULE_18: Waking from dormant clears the request flag
// RULE_19: Shutdown pin honoured only after low-voltage dormant
// RULE_20: Hold old values about 3 s after dormant
// RULE_21: Soft reset restarts and bumps readable counter
// RULE_22: Wake threshold from range and resistor bits
// RULE_23: Wait counter ticks per second in doze, clears
// RULE_24: Host should wake device before charging
module gpm_power_ctrl
  import gpm_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Register port
  input  gpm_pkg::gpm_bus_req_t bus_req,
  output logic [15:0]       bus_rdata_q,
  // Converters and link activity
  input  gpm_pkg::gpm_adc_t adc,
  input  wire logic         link_activity,
  input  wire logic         shutdown_enable_pin,
  // Power and status outputs
  output gpm_pkg::gpm_mode_t mode_q,
  output logic              fast_oscillator_q,
  output logic              link_hold_low_q,
  output logic              cpu_halt_q,
  output logic              firmware_restart_q,
  output logic              shutdown_q,
  output logic              charging_q,
  output logic              discharging_q
);
  import gpm_pkg::*;

  logic [15:0]        doze_current_threshold_q;
  logic [15:0]        dormant_current_threshold_q;
  logic [15:0]        dormant_voltage_threshold_q;
  logic [7:0]         deep_doze_wait_time_q;
  logic [7:0]         config_q;
  logic [31:0]        sec_cnt_q;
  logic               sec_tick;
  logic [4:0]         meas_cnt_q;
  logic               meas_tick;
  logic [7:0]         wait_cnt_q;
  logic               deep_doze_flag_q;
  logic               dormant_req_q;
  logic               relaxed_ocv_q;
  logic               low_v_dormant_q;
  logic [1:0]         hold_cnt_q;
  logic [15:0]        reset_count_q;
  logic [31:0]        settle_cnt_q;
  logic signed [14:0] current_q;
  logic [15:0]        voltage_mv_q;
  logic [15:0]        temp_q;
  logic signed [31:0] charge_acc_q;
  logic signed [15:0] avg_q;
  logic [15:0]        avg_mag;
  logic               wake_q;
  logic               ctl_wr;
  logic               cmd_deep_doze;
  logic               cmd_dormant;
  logic               cmd_soft_reset;
  logic               dormant_ok;
  logic               volt_low;

  assign ctl_wr         = bus_req.wr && (bus_req.addr == REG_CONTROL);
  assign cmd_deep_doze  = ctl_wr && bus_req.wdata[CTL_DEEP_DOZE_REQUEST];
  assign cmd_dormant    = ctl_wr && bus_req.wdata[CTL_DORMANT_REQUEST];
  assign cmd_soft_reset = ctl_wr && bus_req.wdata[CTL_SOFT_RESET];
  assign avg_mag        = avg_q[15] ? 16'(-avg_q) : 16'(avg_q);
  assign volt_low       = voltage_mv_q < dormant_voltage_threshold_q;
  assign dormant_ok     = relaxed_ocv_q && (avg_mag < dormant_current_threshold_q); // [RULE_15]
  assign sec_tick       = (sec_cnt_q == 32'(SECOND_CYCLES - 1));

  // Wake comparator instance
  gpm_wake_cmp u_wake (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .sel     ({config_q[CFG_WAKE_RANGE_SELECT], config_q[CFG_SENSE_RES_SELECT_HI],
               config_q[CFG_SENSE_RES_SELECT_LO]}),
    .sense   (adc.current),
    .wake_q  (wake_q)
  );

  // Configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      doze_current_threshold_q    <= RST_DOZE_CURRENT;
      dormant_current_threshold_q <= RST_DORMANT_CURRENT;
      dormant_voltage_threshold_q <= RST_DORMANT_VOLTAGE;
      deep_doze_wait_time_q       <= RST_DEEP_DOZE_WAIT;
      config_q                    <= RST_CONFIG;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        REG_DOZE_CURRENT_THRESHOLD:    doze_current_threshold_q    <= bus_req.wdata;
        REG_DORMANT_CURRENT_THRESHOLD: dormant_current_threshold_q <= bus_req.wdata;
        REG_DORMANT_VOLTAGE_THRESHOLD: dormant_voltage_threshold_q <= bus_req.wdata;
        REG_DEEP_DOZE_WAIT_TIME:       deep_doze_wait_time_q       <= bus_req.wdata[7:0];
        REG_CONFIG:                    config_q                    <= bus_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata_q <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_DOZE_CURRENT_THRESHOLD:    bus_rdata_q <= doze_current_threshold_q;
        REG_DORMANT_CURRENT_THRESHOLD: bus_rdata_q <= dormant_current_threshold_q;
        REG_DORMANT_VOLTAGE_THRESHOLD: bus_rdata_q <= dormant_voltage_threshold_q;
        REG_DEEP_DOZE_WAIT_TIME:       bus_rdata_q <= {8'h00, deep_doze_wait_time_q};
        REG_CONFIG:                    bus_rdata_q <= {8'h00, config_q};
        REG_STATUS:      bus_rdata_q <= {10'h000, mode_q, fast_oscillator_q,
                                         (hold_cnt_q != 2'd0), dormant_req_q,
                                         deep_doze_flag_q};
        REG_CURRENT:     bus_rdata_q <= {current_q[14], current_q};
        REG_VOLTAGE:     bus_rdata_q <= voltage_mv_q;
        REG_TEMPERATURE: bus_rdata_q <= temp_q;
        REG_RESET_COUNT: bus_rdata_q <= reset_count_q; // [RULE_21]
        REG_CHARGE_ACC:  bus_rdata_q <= charge_acc_q[15:0];
        default:         bus_rdata_q <= '0;
      endcase
    end else begin
      bus_rdata_q <= '0;
    end
  end

  // One-second divider, held at zero in dormant only; it keeps running
  // with the fast oscillator off in deep doze for its 20 s updates
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_q <= '0;
    end else if (mode_q == GPM_DORMANT) begin
      sec_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 32'd1;
    end
  end

  // Measurement cadence: each second in normal, each 20 s in dozes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meas_cnt_q <= '0;
    end else if (mode_q == GPM_NORMAL) begin
      meas_cnt_q <= '0;
    end else if (sec_tick) begin
      meas_cnt_q <= (meas_cnt_q == 5'(DOZE_PERIOD_S - 1)) ? '0 : meas_cnt_q + 5'd1;
    end
  end

  assign meas_tick = sec_tick && ((mode_q == GPM_NORMAL) || // [RULE_05]
                     (meas_cnt_q == 5'(DOZE_PERIOD_S - 1))); // [RULE_06] [RULE_08]

  // Measurement capture, held frozen after dormant exit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      current_q     <= '0;
      voltage_mv_q  <= '0;
      temp_q        <= '0;
      charging_q    <= 1'b0;
      discharging_q <= 1'b0;
    end else if (meas_tick && hold_cnt_q == 2'd0) begin // [RULE_20]
      current_q     <= adc.current; // [RULE_01]
      voltage_mv_q  <= {2'b00, adc.voltage} >> 2; // [RULE_03]
      temp_q        <= config_q[CFG_THERMISTOR_SELECT] ? adc.temp_ext : adc.temp_int; // [RULE_04]
      charging_q    <= !adc.current[14] && (adc.current != '0); // [RULE_02]
      discharging_q <= adc.current[14]; // [RULE_02]
    end
  end

  // Coulomb accumulator and running average
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      charge_acc_q <= '0;
      avg_q        <= '0;
    end else if (meas_tick) begin
      charge_acc_q <= charge_acc_q + 32'(adc.current); // [RULE_01]
      avg_q        <= 16'((32'(avg_q) + 32'(adc.current)) >>> 1);
    end
  end

  // Deep doze wait counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt_q <= '0;
    end else if (mode_q == GPM_DEEP_DOZE && link_activity) begin
      wait_cnt_q <= '0; // [RULE_13]
    end else if (mode_q == GPM_DOZE && avg_mag >= doze_current_threshold_q) begin
      wait_cnt_q <= '0; // [RULE_23]
    end else if (mode_q == GPM_DOZE && sec_tick) begin
      wait_cnt_q <= wait_cnt_q + 8'd1; // [RULE_23]
    end
  end

  // Relaxed open-circuit reading flag, set by software
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      relaxed_ocv_q <= 1'b0;
    end else if (ctl_wr) begin
      relaxed_ocv_q <= bus_req.wdata[CTL_RELAXED_OCV];
    end
  end

  // Dormant request flag: wake clears, request write sets
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dormant_req_q <= 1'b0;
    end else if (cmd_dormant) begin
      dormant_req_q <= 1'b1;
    end else if (mode_q == GPM_DORMANT &&
                 (link_activity || avg_mag > dormant_current_threshold_q)) begin
      dormant_req_q <= 1'b0; // [RULE_18]
    end
  end

  // Mode sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q           <= GPM_NORMAL;
      deep_doze_flag_q <= 1'b0;
      low_v_dormant_q  <= 1'b0;
    end else begin
      unique case (mode_q)
        GPM_NORMAL, GPM_DOZE: begin
          if ((dormant_req_q || volt_low) && dormant_ok) begin // [RULE_15]
            mode_q          <= GPM_DORMANT; // [RULE_16]
            low_v_dormant_q <= volt_low && !dormant_req_q;
          end else if (mode_q == GPM_NORMAL) begin
            if (config_q[CFG_DOZE_ENABLE] && avg_mag < doze_current_threshold_q) begin
              mode_q <= GPM_DOZE; // [RULE_07]
            end
          end else if (avg_mag >= doze_current_threshold_q) begin
            mode_q <= GPM_NORMAL;
          end else if (deep_doze_wait_time_q != 8'd0 &&
                       wait_cnt_q >= deep_doze_wait_time_q) begin
            mode_q           <= GPM_DEEP_DOZE; // [RULE_10]
            deep_doze_flag_q <= 1'b1;
          end else if (cmd_deep_doze && deep_doze_wait_time_q == 8'd0) begin // [RULE_12]
            mode_q           <= GPM_DEEP_DOZE; // [RULE_11]
            deep_doze_flag_q <= 1'b1;
          end
        end
        GPM_DEEP_DOZE: begin
          if (link_activity || avg_mag > doze_current_threshold_q || wake_q) begin
            mode_q           <= GPM_NORMAL; // [RULE_14]
            deep_doze_flag_q <= 1'b0;
          end
        end
        GPM_DORMANT: begin
          if (link_activity || avg_mag > dormant_current_threshold_q) begin
            mode_q          <= GPM_NORMAL; // [RULE_17]
            low_v_dormant_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Value hold for three seconds after leaving dormant
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt_q <= '0;
    end else if (mode_q == GPM_DORMANT) begin
      hold_cnt_q <= 2'(HOLD_VALUES_S); // [RULE_20]
    end else if (sec_tick && hold_cnt_q != 2'd0) begin
      hold_cnt_q <= hold_cnt_q - 2'd1;
    end
  end

  // Oscillator control and settle stretch on deep-doze exit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fast_oscillator_q <= 1'b1;
      link_hold_low_q   <= 1'b0;
      settle_cnt_q      <= '0;
    end else if (mode_q == GPM_DEEP_DOZE) begin
      fast_oscillator_q <= 1'b0; // [RULE_08]
      link_hold_low_q   <= 1'b0;
      settle_cnt_q      <= 32'(OSC_SETTLE_CYCLES);
    end else begin
      fast_oscillator_q <= 1'b1;
      link_hold_low_q   <= settle_cnt_q > 32'd1; // [RULE_09]
      settle_cnt_q      <= (settle_cnt_q != '0) ? settle_cnt_q - 32'd1 : '0;
    end
  end

  // Processor halt, shutdown and soft reset outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_halt_q         <= 1'b0;
      shutdown_q         <= 1'b0;
      firmware_restart_q <= 1'b0;
      reset_count_q      <= '0;
    end else begin
      cpu_halt_q         <= (mode_q == GPM_DOZE) || (mode_q == GPM_DEEP_DOZE); // [RULE_06]
      shutdown_q         <= (mode_q == GPM_DORMANT) && low_v_dormant_q &&
                            shutdown_enable_pin; // [RULE_19]
      firmware_restart_q <= cmd_soft_reset; // [RULE_21]
      if (cmd_soft_reset) begin
        reset_count_q <= reset_count_q + 16'd1; // [RULE_21]
      end
    end
  end

  // Sequencer and output checks
  deep_doze_cmd_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_11]
    (mode_q == GPM_DOZE && cmd_deep_doze && deep_doze_wait_time_q == 8'd0 &&
     !((dormant_req_q || volt_low) && dormant_ok) && avg_mag < doze_current_threshold_q)
    |=> mode_q == GPM_DEEP_DOZE && deep_doze_flag_q) else $error("deep doze cmd lost");
  deep_doze_ign_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_12]
    (mode_q == GPM_DOZE && deep_doze_wait_time_q != 8'd0 &&
     wait_cnt_q < deep_doze_wait_time_q) |=> mode_q != GPM_DEEP_DOZE)
    else $error("deep doze entered early");
  comm_wake_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_13]
    (mode_q == GPM_DEEP_DOZE && link_activity) |=> wait_cnt_q == 8'd0 && mode_q == GPM_NORMAL)
    else $error("comm wake did not reset");
  wake_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_14]
    (mode_q == GPM_DEEP_DOZE && wake_q) |=> mode_q == GPM_NORMAL)
    else $error("wake comparator ignored");
  osc_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_08]
    (mode_q == GPM_DEEP_DOZE) ##1 (mode_q == GPM_DEEP_DOZE) |-> !fast_oscillator_q)
    else $error("oscillator on in deep doze");
  dormant_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_18]
    (mode_q == GPM_DORMANT && link_activity && !cmd_dormant) |=> !dormant_req_q)
    else $error("dormant request not cleared");
  shutdown_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_19]
    shutdown_q |-> $past(low_v_dormant_q) && $past(mode_q == GPM_DORMANT))
    else $error("shutdown without low voltage");
  reset_count_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_21]
    cmd_soft_reset |=> firmware_restart_q && reset_count_q == $past(reset_count_q) + 16'd1)
    else $error("soft reset not counted");
  doze_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07]
    (mode_q == GPM_NORMAL && avg_mag >= doze_current_threshold_q) |=> mode_q != GPM_DOZE)
    else $error("doze entered with high current");
  hold_low_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_09]
    $fell(mode_q == GPM_DEEP_DOZE) |-> link_hold_low_q == 1'b0 ##1 link_hold_low_q)
    else $error("no settle stretch");
endmodule : gpm_power_ctrl

//--- inc/gpm_pkg.sv
package gpm_pkg;

  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0]  REG_DOZE_CURRENT_THRESHOLD    = 8'h02;
  localparam logic [7:0]  REG_DORMANT_CURRENT_THRESHOLD = 8'h09;
  localparam logic [7:0]  REG_DORMANT_VOLTAGE_THRESHOLD = 8'h0B;
  localparam logic [7:0]  REG_DEEP_DOZE_WAIT_TIME       = 8'h0D;
  localparam logic [7:0]  REG_CONFIG                    = 8'h10;
  localparam logic [7:0]  REG_CONTROL                   = 8'h11;
  localparam logic [7:0]  REG_STATUS                    = 8'h12;
  localparam logic [7:0]  REG_CURRENT                   = 8'h13;
  localparam logic [7:0]  REG_VOLTAGE                   = 8'h14;
  localparam logic [7:0]  REG_TEMPERATURE               = 8'h15;
  localparam logic [7:0]  REG_RESET_COUNT               = 8'h16;
  localparam logic [7:0]  REG_CHARGE_ACC                = 8'h17;

  // Reset values
  localparam logic [15:0] RST_DOZE_CURRENT    = 16'h000F;
  localparam logic [15:0] RST_DORMANT_CURRENT = 16'h0008;
  localparam logic [15:0] RST_DORMANT_VOLTAGE = 16'h09F6;
  localparam logic [7:0]  RST_DEEP_DOZE_WAIT  = 8'h00;
  localparam logic [7:0]  RST_CONFIG          = 8'h1B;

  // Configuration field positions
  localparam int CFG_THERMISTOR_SELECT   = 0;
  localparam int CFG_DOZE_ENABLE         = 1;
  localparam int CFG_SENSE_RES_SELECT_LO = 2;
  localparam int CFG_SENSE_RES_SELECT_HI = 3;
  localparam int CFG_WAKE_RANGE_SELECT   = 4;

  // Control register write bits
  localparam int CTL_DEEP_DOZE_REQUEST = 0;
  localparam int CTL_DORMANT_REQUEST   = 1;
  localparam int CTL_SOFT_RESET        = 2;
  localparam int CTL_RELAXED_OCV       = 3;

  // Status register bit positions
  localparam int STS_DEEP_DOZE   = 0;
  localparam int STS_DORMANT_REQ = 1;
  localparam int STS_HOLD_VALUES = 2;
  localparam int STS_FAST_OSC_ON = 3;
  localparam int STS_MODE_LSB    = 4;

  // Timing
  localparam int  CLK_HZ            = 100_000_000;
  localparam int  SECOND_S          = 1;
  localparam int  SECOND_CYCLES     = SECOND_S * CLK_HZ;
  localparam int  DOZE_PERIOD_S     = 20;
  localparam int  HOLD_VALUES_S     = 3;
  localparam int  OSC_SETTLE_US     = 4000;
  localparam int  OSC_SETTLE_CYCLES = OSC_SETTLE_US * (CLK_HZ / 1_000_000);

  // Wake thresholds in 10 uV steps of the current converter
  localparam logic [14:0] WAKE_TH_1P0 = 15'h0064;
  localparam logic [14:0] WAKE_TH_2P2 = 15'h00DC;
  localparam logic [14:0] WAKE_TH_4P6 = 15'h01CC;
  localparam logic [14:0] WAKE_TH_9P8 = 15'h03D4;

  typedef enum logic [1:0] {
    GPM_NORMAL,
    GPM_DOZE,
    GPM_DEEP_DOZE,
    GPM_DORMANT
  } gpm_mode_t;

  // Software register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gpm_bus_req_t;

  // Raw converter samples
  typedef struct packed {
    logic signed [14:0] current;
    logic [13:0]        voltage;
    logic [15:0]        temp_ext;
    logic [15:0]        temp_int;
  } gpm_adc_t;

endpackage : gpm_pkg

//--- hw/gpm_wake_cmp.sv
`timescale 1ns/10ps
// Wake comparator: flags a sense level beyond the selected threshold
module gpm_wake_cmp
  import gpm_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // Configuration
  input  wire logic [2:0]         sel,
  // Sense sample
  input  wire logic signed [14:0] sense,
  // Result
  output logic                    wake_q
);
  logic [14:0] th;
  logic [14:0] mag;

  // Threshold from range and resistor select
  always_comb begin
    unique case (sel)
      3'b001:          th = WAKE_TH_1P0;
      3'b101, 3'b010:  th = WAKE_TH_2P2;
      3'b110, 3'b011:  th = WAKE_TH_4P6;
      3'b111:          th = WAKE_TH_9P8;
      default:         th = '0;
    endcase
  end

  assign mag = sense[14] ? 15'(-sense) : 15'(sense);

  // Either direction breaches; select bits zero disable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (sel[1:0] != 2'b00) && (mag > th); // [RULE_22]
    end
  end

  wake_cmp_off_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_22]
    (sel[1:0] == 2'b00) |=> !wake_q) else $error("wake raised while disabled");
endmodule : gpm_wake_cmp

//--- test/gpm_host_model.sv
`timescale 1ns/10ps
// Host side of the serial link plus the analog front end seen by the gauge
module gpm_host_model
  import gpm_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Bench control
  input  wire logic        poke,
  input  wire logic        hold_low,
  // Towards the gauge
  output gpm_pkg::gpm_adc_t adc,
  output logic             link_activity
);
  // Idle until the bench asks for traffic
  initial begin
    adc           = '0;
    link_activity = 1'b0;
  end

  // Commands are dropped while the gauge stretches the lines low
  always @(posedge sys_clk) begin
    link_activity     <= poke & ~hold_low;
    adc.current       <= 15'($urandom_range(0, 50)); // Small charge only
    adc.voltage       <= 14'($urandom_range(12000, 16000));
    adc.temp_ext      <= 16'($urandom);
    adc.temp_int      <= 16'($urandom);
  end
endmodule : gpm_host_model

//--- test/gauge_power_mode_control_bench.sv
`timescale 1ns/10ps
module gauge_power_mode_control_bench;
  import gpm_pkg::*;
  logic               sys_clk, resetn, link_activity, shutdown_enable_pin, poke;
  gpm_bus_req_t       bus_req;
  gpm_adc_t           adc;
  logic [15:0]        bus_rdata_q, got, v;
  gpm_mode_t          mode_q;
  logic               fast_oscillator_q, link_hold_low_q, cpu_halt_q, firmware_restart_q;
  logic               shutdown_q, charging_q, discharging_q;
  int                 err_total, cmp_count, n;
  logic [15:0]        exp_q[logic [7:0]];

  gpm_power_ctrl dut (
    .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata_q(bus_rdata_q),
    .adc(adc), .link_activity(link_activity), .shutdown_enable_pin(shutdown_enable_pin),
    .mode_q(mode_q), .fast_oscillator_q(fast_oscillator_q),
    .link_hold_low_q(link_hold_low_q), .cpu_halt_q(cpu_halt_q),
    .firmware_restart_q(firmware_restart_q), .shutdown_q(shutdown_q),
    .charging_q(charging_q), .discharging_q(discharging_q));

  gpm_host_model host (
    .sys_clk(sys_clk), .poke(poke), .hold_low(link_hold_low_q), .adc(adc),
    .link_activity(link_activity));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask : wr_reg

  // Read strobe, data in the next cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1 d = bus_rdata_q;
    @(posedge sys_clk);
    #1 chk(bus_rdata_q, 16'h0000);
  endtask : rd_reg

  // One command on the link, then three edges for the device to react
  task automatic send_cmd;
    @(posedge sys_clk);
    poke <= 1'b1;
    @(posedge sys_clk);
    poke <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : send_cmd

  // Verdict
  task automatic end_sim;
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    err_total = 0;
    cmp_count = 0;
    resetn = 1'b0;
    bus_req = '0;
    shutdown_enable_pin = 1'b0;
    poke = 1'b0;
    v = 16'($urandom(32'hEC6F));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    exp_q[REG_DOZE_CURRENT_THRESHOLD]    = RST_DOZE_CURRENT;
    exp_q[REG_DORMANT_CURRENT_THRESHOLD] = RST_DORMANT_CURRENT;
    exp_q[REG_DORMANT_VOLTAGE_THRESHOLD] = RST_DORMANT_VOLTAGE;
    exp_q[REG_DEEP_DOZE_WAIT_TIME]       = {8'h00, RST_DEEP_DOZE_WAIT};
    exp_q[REG_CONFIG]                    = {8'h00, RST_CONFIG};
    // Reset values
    foreach (exp_q[a]) begin
      rd_reg(a, got);
      chk(got, exp_q[a]);
    end
    // Doze is enabled out of reset and the average current is zero
    #1 chk({14'h0000, mode_q}, {14'h0000, GPM_DOZE});
    chk({15'h0000, cpu_halt_q}, 16'h0001);
    chk({14'h0000, charging_q, discharging_q}, 16'h0000);
    // Relaxed reading with no voltage measured yet means low voltage
    @(posedge sys_clk);
    shutdown_enable_pin <= 1'b1;
    wr_reg(REG_CONTROL, 16'h0008);
    repeat (3) @(posedge sys_clk);
    #1 chk({14'h0000, mode_q}, {14'h0000, GPM_DORMANT});
    chk({15'h0000, shutdown_q}, 16'h0001);
    // Set the request flag, then a command wakes and clears it
    wr_reg(REG_CONTROL, 16'h0002);
    send_cmd();
    #1 chk({15'h0000, shutdown_q}, 16'h0000);
    rd_reg(REG_STATUS, got);
    chk(got & 16'h0036, 16'h0014);
    // Deep doze on command with a zero wait, oscillator stops
    wr_reg(REG_CONTROL, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1 chk({14'h0000, mode_q}, {14'h0000, GPM_DEEP_DOZE});
    chk({15'h0000, fast_oscillator_q}, 16'h0000);
    rd_reg(REG_STATUS, got);
    chk(got & 16'h0039, 16'h0021);
    // Zero doze threshold keeps the device awake after a command wake
    wr_reg(REG_DOZE_CURRENT_THRESHOLD, 16'h0000);
    send_cmd();
    #1 chk({14'h0000, mode_q}, {14'h0000, GPM_NORMAL});
    chk({15'h0000, link_hold_low_q}, 16'h0001);
    chk({15'h0000, fast_oscillator_q}, 16'h0001);
    // Random writes, the wait time keeps only its low byte
    foreach (exp_q[a]) begin
      if (a != REG_CONFIG) begin
        v = 16'($urandom);
        wr_reg(a, v);
        exp_q[a] = (a == REG_DEEP_DOZE_WAIT_TIME) ? {8'h00, v[7:0]} : v;
      end
    end
    foreach (exp_q[a]) begin
      rd_reg(a, got);
      chk(got, exp_q[a]);
    end
    // Unmapped index reads as zero
    rd_reg(8'h3F, got);
    chk(got, 16'h0000);
    // A zero doze threshold returns to normal; the command is dropped while the lines are still held low
    wr_reg(REG_DOZE_CURRENT_THRESHOLD, 16'h0000);
    send_cmd();
    #1 chk({14'h0000, mode_q}, 16'h0000);
    chk({15'h0000, fast_oscillator_q}, 16'h0001);
    chk({15'h0000, cpu_halt_q}, 16'h0000);
    rd_reg(REG_STATUS, got);
    chk(got & 16'h0039, 16'h0008);
    // Soft reset pulses once per write and bumps the counter
    for (int i = 1; i <= 3; i++) begin
      wr_reg(REG_CONTROL, 16'h0004);
      n = 0;
      repeat (4) begin
        #1 n += int'(firmware_restart_q === 1'b1);
        @(posedge sys_clk);
      end
      chk(16'(n), 16'h0001);
      rd_reg(REG_RESET_COUNT, got);
      chk(got, 16'(i));
    end
    end_sim();
  end
endmodule : gauge_power_mode_control_bench
